// file: rtl/aux_pin_ctrl.sv
// Auxiliary host pin controller with AHB-Lite register slave
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module aux_pin_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [2:0] bus_mode_select,
  input wire logic autostart_n,
  input wire logic tree_test_enable_n,
  output logic tree_test_output_o,
  output logic tree_test_output_oe,
  output logic pullup_en,
  output logic test_mode,
  input wire logic memory_locality_select_i,
  output logic memory_locality_select_o,
  output logic memory_locality_select_oe,
  input wire logic bus_fault_ack_n_i,
  output logic bus_fault_ack_n_o,
  output logic bus_fault_ack_n_oe,
  input wire logic transfer_active_n_i,
  output logic transfer_active_n_o,
  output logic transfer_active_n_oe,
  input wire logic transfer_ack_ready_n,
  input wire logic [31:0] fetch_data,
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  input wire logic illegal_access,
  input wire logic [aux_pin_pkg::GPIO_W-1:0] gpio_i,
  output logic [aux_pin_pkg::GPIO_W-1:0] gpio_o,
  output logic [aux_pin_pkg::GPIO_W-1:0] gpio_oe,
  input wire logic [aux_pin_pkg::HOST_PINS_W-1:0] host_pins_i,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic mode_one(input logic [2:0] bs);
    mode_one = bs[2] & bs[0];
  endfunction

  function automatic logic [31:0] read_reg(input logic [7:0] addr,
                                           input aux_pin_pkg::state_s s);
    read_reg = 32'h0000_0000;
    case (addr)
      aux_pin_pkg::CTRL_OFS: read_reg[0] = s.locality;
      aux_pin_pkg::PTR_OFS: read_reg = s.ptr;
      aux_pin_pkg::GPIO_DIR_OFS: read_reg[4:0] = s.gpio_dir;
      aux_pin_pkg::GPIO_OUT_OFS: read_reg[4:0] = s.gpio_out;
      aux_pin_pkg::GPIO_IN_OFS: read_reg[4:0] = s.sync2.gpio;
      aux_pin_pkg::STATUS_OFS: read_reg[3:0] = s.status;
      aux_pin_pkg::MASK_OFS: read_reg[3:0] = s.mask;
      aux_pin_pkg::STATE_OFS: begin
        read_reg[2:0] = s.state;
        read_reg[6:4] = s.sync2.bus_mode_select;
        read_reg[8] = s.test_mode;
        read_reg[9] = s.sync2.autostart_n;
      end
      aux_pin_pkg::INSTR_OFS: read_reg = s.instr;
      aux_pin_pkg::RETRY_OFS: read_reg[7:0] = s.retries;
      default: read_reg = 32'h0000_0000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  aux_pin_pkg::state_s st_q;
  aux_pin_pkg::state_s st_d;
  aux_pin_pkg::pins_s pins_in;
  logic [aux_pin_pkg::STATUS_W-1:0] events;
  logic [aux_pin_pkg::STATUS_W-1:0] w1c;
  logic m1;
  logic ack;
  logic retry;
  logic fatal;
  logic mastering;
  logic ptr_wr;
  logic wr;

  always_comb begin
    pins_in.bus_mode_select = bus_mode_select;
    pins_in.autostart_n = autostart_n;
    pins_in.halt_n = transfer_active_n_i;
    pins_in.transfer_ack_ready_n = transfer_ack_ready_n;
    pins_in.bus_fault_ack_n = bus_fault_ack_n_i;
    pins_in.tree_test_enable_n = tree_test_enable_n;
    pins_in.memory_locality_select = memory_locality_select_i;
    pins_in.gpio = gpio_i;
    pins_in.fetch_data = fetch_data;
    pins_in.host_pins = host_pins_i;
  end

  always_comb begin
    st_d = st_q;
    events = '0;
    w1c = '0;
    // Pin inputs pass two flip-flops
    st_d.sync1 = pins_in;
    st_d.sync2 = st_q.sync1;
    m1 = mode_one(st_q.sync2.bus_mode_select);
    ack = !st_q.sync2.transfer_ack_ready_n;
    retry = 1'b0;
    fatal = 1'b0;
    if (m1) begin
      // Fault with halt asks for the same cycle again
      retry = !st_q.sync2.bus_fault_ack_n && !st_q.sync2.halt_n;
      fatal = !st_q.sync2.bus_fault_ack_n && st_q.sync2.halt_n;
    end else begin
      // Error with ack/ready asks for the same transfer again
      retry = !st_q.sync2.bus_fault_ack_n && ack;
      fatal = !st_q.sync2.bus_fault_ack_n && !ack;
    end

    //////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait, always OKAY
    wr = st_q.a_valid && st_q.a_write;
    ptr_wr = wr && (st_q.a_addr == aux_pin_pkg::PTR_OFS);
    st_d.a_valid = 1'b0;
    if (hsel && hready && htrans[1]) begin
      st_d.a_valid = 1'b1;
      st_d.a_write = hwrite;
      st_d.a_addr = {haddr[7:2], 2'b00};
      if (!hwrite) begin
        st_d.hrdata = read_reg({haddr[7:2], 2'b00}, st_q);
      end
    end
    if (wr) begin
      case (st_q.a_addr)
        aux_pin_pkg::CTRL_OFS:
          st_d.locality = hwdata[aux_pin_pkg::CTRL_LOCAL_BIT];
        aux_pin_pkg::PTR_OFS: st_d.ptr = hwdata;
        aux_pin_pkg::GPIO_DIR_OFS: st_d.gpio_dir = hwdata[4:0];
        aux_pin_pkg::GPIO_OUT_OFS: st_d.gpio_out = hwdata[4:0];
        aux_pin_pkg::STATUS_OFS: w1c = hwdata[3:0];
        aux_pin_pkg::MASK_OFS: st_d.mask = hwdata[3:0];
        default: ;
      endcase
    end

    //////////////////////////////////////////////////////////////////////
    // Script engine
    case (st_q.state)
      aux_pin_pkg::ST_BOOT: begin
        if (st_q.boot_cnt == aux_pin_pkg::BOOT_WAIT) begin
          if (!st_q.sync2.autostart_n) begin
            st_d.ptr = aux_pin_pkg::PTR_RST;
            st_d.state = aux_pin_pkg::ST_BUS;
          end else begin
            st_d.state = aux_pin_pkg::ST_IDLE;
          end
        end else begin
          st_d.boot_cnt = st_q.boot_cnt + 2'h1;
        end
      end
      aux_pin_pkg::ST_IDLE: begin
        if (ptr_wr) begin
          st_d.state = aux_pin_pkg::ST_BUS;
        end
      end
      aux_pin_pkg::ST_BUS: begin
        // Only an answer to a request still out counts, and only once
        if (retry && st_q.fetch_req) begin
          events[aux_pin_pkg::ST_RETRY_BIT] = 1'b1;
          st_d.retries = st_q.retries + 8'h01;
        end else if (fatal && st_q.fetch_req) begin
          events[aux_pin_pkg::ST_FATAL_BIT] = 1'b1;
          st_d.state = aux_pin_pkg::ST_IDLE;
        end else if (ack && st_q.fetch_req) begin
          st_d.instr = st_q.sync2.fetch_data;
          st_d.state = aux_pin_pkg::ST_EXEC;
        end
      end
      aux_pin_pkg::ST_EXEC: begin
        st_d.ptr = st_q.ptr + aux_pin_pkg::PTR_STEP;
        if (st_q.instr[31:24] == aux_pin_pkg::INT_OPCODE) begin
          events[aux_pin_pkg::ST_INT_BIT] = 1'b1;
          st_d.state = aux_pin_pkg::ST_IDLE;
        end else begin
          st_d.state = aux_pin_pkg::ST_BUS;
        end
      end
      default: st_d.state = aux_pin_pkg::ST_IDLE;
    endcase
    // Next request waits until the last answer has left the synchroniser
    st_d.fetch_req = (st_d.state == aux_pin_pkg::ST_BUS) && !ack &&
                     st_q.sync2.bus_fault_ack_n;
    mastering = st_d.state == aux_pin_pkg::ST_BUS;

    //////////////////////////////////////////////////////////////////////
    // Sticky status, set wins over clear
    events[aux_pin_pkg::ST_ILLEGAL_BIT] = illegal_access;
    st_d.status = (st_q.status & ~w1c) | events;
    st_d.irq = |(st_d.status & st_d.mask);

    //////////////////////////////////////////////////////////////////////
    // Tree test and pin drive
    st_d.test_mode = !st_q.sync2.tree_test_enable_n;
    // Only host-side pins; no SCSI line is wired into this block
    st_d.tree_out = &{st_q.sync2.bus_mode_select,
                      st_q.sync2.autostart_n,
                      st_q.sync2.halt_n,
                      st_q.sync2.transfer_ack_ready_n,
                      st_q.sync2.bus_fault_ack_n,
                      st_q.sync2.memory_locality_select,
                      st_q.sync2.gpio,
                      st_q.sync2.fetch_data,
                      st_q.sync2.host_pins};
    st_d.fault_oe = illegal_access && !st_d.test_mode;
    st_d.tip_oe = mastering && !m1 && !st_d.test_mode;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.sync1 <= '1;
      st_q.sync2 <= '1;
      st_q.state <= aux_pin_pkg::ST_BOOT;
      st_q.ptr <= aux_pin_pkg::PTR_RST;
      st_q.locality <= 1'b0;
      st_q.gpio_dir <= aux_pin_pkg::GPIO_DIR_RST;
      st_q.gpio_out <= aux_pin_pkg::GPIO_OUT_RST;
      st_q.tree_out <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops or tied to constants
  logic [aux_pin_pkg::GPIO_W-1:0] gpio_oe_q;
  logic loc_oe_q;
  logic tree_oe_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gpio_oe_q <= '0;
      loc_oe_q <= 1'b0;
      tree_oe_q <= 1'b0;
    end else begin
      gpio_oe_q <= st_d.test_mode ? '0 : st_d.gpio_dir;
      loc_oe_q <= !st_d.test_mode;
      tree_oe_q <= st_d.test_mode;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_q.hrdata;
  assign tree_test_output_o = st_q.tree_out;
  assign tree_test_output_oe = tree_oe_q;
  assign pullup_en = st_q.test_mode;
  assign test_mode = st_q.test_mode;
  assign memory_locality_select_o = st_q.locality;
  assign memory_locality_select_oe = loc_oe_q;
  assign bus_fault_ack_n_o = 1'b0;
  assign bus_fault_ack_n_oe = st_q.fault_oe;
  assign transfer_active_n_o = 1'b0;
  assign transfer_active_n_oe = st_q.tip_oe;
  assign fetch_req = st_q.fetch_req;
  assign fetch_addr = st_q.ptr;
  assign gpio_o = st_q.gpio_out;
  assign gpio_oe = gpio_oe_q;
  assign irq = st_q.irq;

endmodule

// file: pkg/aux_pin_pkg.sv
// Constants, types and register map of the auxiliary host pin controller
package aux_pin_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PTR_OFS = 8'h04;
  localparam logic [7:0] GPIO_DIR_OFS = 8'h08;
  localparam logic [7:0] GPIO_OUT_OFS = 8'h0c;
  localparam logic [7:0] GPIO_IN_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] MASK_OFS = 8'h18;
  localparam logic [7:0] STATE_OFS = 8'h1c;
  localparam logic [7:0] INSTR_OFS = 8'h20;
  localparam logic [7:0] RETRY_OFS = 8'h24;

  ////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int CTRL_LOCAL_BIT = 0;
  localparam int ST_RETRY_BIT = 0;
  localparam int ST_FATAL_BIT = 1;
  localparam int ST_INT_BIT = 2;
  localparam int ST_ILLEGAL_BIT = 3;
  localparam int STATUS_W = 4;
  localparam int GPIO_W = 5;
  localparam int HOST_PINS_W = 16;
  localparam logic [4:0] GPIO_DIR_RST = 5'h10;
  localparam logic [4:0] GPIO_OUT_RST = 5'h00;
  localparam logic [31:0] PTR_RST = 32'h0000_0000;
  localparam logic [31:0] PTR_STEP = 32'h0000_0004;
  localparam logic [7:0] INT_OPCODE = 8'h98;
  localparam logic [1:0] BOOT_WAIT = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_BUS,
    ST_EXEC
  } engine_e;

  typedef struct packed {
    logic [2:0] bus_mode_select;
    logic autostart_n;
    logic halt_n;
    logic transfer_ack_ready_n;
    logic bus_fault_ack_n;
    logic tree_test_enable_n;
    logic memory_locality_select;
    logic [GPIO_W-1:0] gpio;
    logic [31:0] fetch_data;
    logic [HOST_PINS_W-1:0] host_pins;
  } pins_s;

  typedef struct packed {
    pins_s sync1;
    pins_s sync2;
    engine_e state;
    logic [1:0] boot_cnt;
    logic [31:0] ptr;
    logic [31:0] instr;
    logic [7:0] retries;
    logic locality;
    logic [GPIO_W-1:0] gpio_dir;
    logic [GPIO_W-1:0] gpio_out;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] mask;
    logic a_valid;
    logic a_write;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic test_mode;
    logic tree_out;
    logic fault_oe;
    logic tip_oe;
    logic fetch_req;
    logic irq;
  } state_s;

endpackage

// file: dv/aux_pin_ctrl_props.sv
// Port assertions of the auxiliary host pin controller
`timescale 1ns/1ps
module aux_pin_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [2:0] bus_mode_select,
  input wire logic tree_test_enable_n,
  input wire logic tree_test_output_oe,
  input wire logic pullup_en,
  input wire logic test_mode,
  input wire logic memory_locality_select_oe,
  input wire logic bus_fault_ack_n_i,
  input wire logic bus_fault_ack_n_oe,
  input wire logic transfer_active_n_oe,
  input wire logic transfer_ack_ready_n,
  input wire logic fetch_req,
  input wire logic illegal_access,
  input wire logic [aux_pin_pkg::GPIO_W-1:0] gpio_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  chk_test_quiet: assert property (tree_test_output_oe |->
    !memory_locality_select_oe && !bus_fault_ack_n_oe &&
    !transfer_active_n_oe && gpio_oe == '0) else $error("driver on in test");
  chk_tree_enter: assert property (!tree_test_enable_n [*4] |->
    tree_test_output_oe) else $error("tree output not enabled");
  chk_tree_leave: assert property (tree_test_enable_n [*4] |->
    !tree_test_output_oe) else $error("tree output not released");
  chk_pullup_tie: assert property (pullup_en == tree_test_output_oe &&
    test_mode == pullup_en) else $error("pull-up enable mismatch");
  chk_fault_pulse: assert property (illegal_access && !test_mode |->
    ##[1:2] bus_fault_ack_n_oe ##1 !bus_fault_ack_n_oe)
    else $error("fault acknowledge pulse wrong");
  chk_tip_mode1: assert property (bus_mode_select[2] &&
    bus_mode_select[0] |-> !transfer_active_n_oe)
    else $error("transfer active driven in mode 1");
  chk_loc_drive: assert property (tree_test_enable_n [*5] |->
    memory_locality_select_oe) else $error("locality not driven");
  chk_fetch_hold: assert property ((transfer_ack_ready_n &&
    bus_fault_ack_n_i) [*3] ##0 fetch_req |=> fetch_req)
    else $error("fetch dropped without answer");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response not okay");
  cover property (illegal_access);
  cover property ($rose(tree_test_output_oe));
  cover property ($rose(transfer_active_n_oe));
endmodule
bind aux_pin_ctrl aux_pin_props i_aux_pin_props (.clock, .rst_n, .hreadyout,
  .hresp, .bus_mode_select, .tree_test_enable_n, .tree_test_output_oe,
  .pullup_en, .test_mode, .memory_locality_select_oe, .bus_fault_ack_n_i,
  .bus_fault_ack_n_oe, .transfer_active_n_oe, .transfer_ack_ready_n,
  .fetch_req, .illegal_access, .gpio_oe);

// file: dv/host_mem_model.sv
// Host bus and memory partner answering instruction fetches
`timescale 1ns/1ps
module host_mem_model (
  input wire logic clock,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic mode1,
  output logic ready_n,
  output logic fault_n,
  output logic halt_n,
  output logic [31:0] data
);
  int retries = 0;
  int dly = 0;
  logic fatal = 1'b0;
  initial begin
    ready_n = 1'b1;
    fault_n = 1'b1;
    halt_n = 1'b1;
    data = '1;
    forever begin
      @(posedge clock);
      if (fetch_req === 1'b1) begin
        repeat (dly) @(posedge clock);
        dly = 2 - dly;
        data <= fetch_addr[3:0] == 4'h8 ?
          {aux_pin_pkg::INT_OPCODE, 24'h0} : fetch_addr;
        fault_n <= !(fatal || retries > 0);
        halt_n <= !(mode1 && retries > 0);
        ready_n <= fatal || (mode1 && retries > 0);
        repeat (20) if (fetch_req === 1'b1) @(posedge clock);
        if (retries > 0) retries--;
        ready_n <= 1'b1;
        fault_n <= 1'b1;
        halt_n <= 1'b1;
        // Released data bus rests at its pull-up level
        data <= '1;
        repeat (2) @(posedge clock);
      end
    end
  end
endmodule

// file: dv/testbench.sv
// Self-checking bench of the auxiliary host pin controller
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
  logic clock = 0, rst_n = 0, hwrite = 0, autostart_n = 0;
  logic tree_test_enable_n = 1, illegal_access = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] bus_mode_select = 3'h4;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, fetch_addr, fetch_data;
  logic [31:0] rd;
  logic [15:0] host_pins_i = 16'hffff;
  logic [4:0] gpio_o, gpio_oe;
  logic hreadyout, fetch_req, irq, ready_n, fault_n, halt_n, pu;
  logic tree_o, tree_oe, loc_o, loc_oe, flt_o, flt_oe, tip_o, tip_oe;
  wire flt_w = ~(flt_oe & ~flt_o) & fault_n;
  wire tip_w = (tip_oe ? tip_o : 1'b1) & halt_n;
  wire loc_w = loc_oe ? loc_o : 1'b1;
  wire tree_w = tree_oe ? tree_o : 1'b1;
  wire [4:0] gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & (pu ? 5'h1f : 5'h0a));
  int fails = 0, tests_run = 0;
  typedef struct packed {
    logic w; logic [7:0] a; logic [31:0] d; logic loc; logic [4:0] oe;
  } row_s;
  row_s rows [8] = '{'{0, 8'h00, 32'h0, 0, 5'h10},
    '{0, 8'h08, 32'h10, 0, 5'h10}, '{1, 8'h00, 32'h1, 1, 5'h10},
    '{0, 8'h00, 32'h1, 1, 5'h10}, '{0, 8'h10, 32'h0a, 1, 5'h10},
    '{1, 8'h08, 32'h1f, 1, 5'h1f}, '{0, 8'h3c, 32'h0, 1, 5'h1f},
    '{1, 8'h08, 32'h10, 1, 5'h10}};
  always #5 clock = ~clock;
  aux_pin_ctrl i_aux_pin_ctrl (.clock, .rst_n, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp(), .hrdata, .bus_mode_select, .autostart_n, .tree_test_enable_n,
    .tree_test_output_o(tree_o), .tree_test_output_oe(tree_oe),
    .pullup_en(pu), .test_mode(), .memory_locality_select_i(loc_w),
    .memory_locality_select_o(loc_o), .memory_locality_select_oe(loc_oe),
    .bus_fault_ack_n_i(flt_w), .bus_fault_ack_n_o(flt_o),
    .bus_fault_ack_n_oe(flt_oe), .transfer_active_n_i(tip_w),
    .transfer_active_n_o(tip_o), .transfer_active_n_oe(tip_oe),
    .transfer_ack_ready_n(ready_n), .fetch_data, .fetch_req, .fetch_addr,
    .illegal_access, .gpio_i, .gpio_o, .gpio_oe, .host_pins_i, .irq);
  host_mem_model i_host_mem_model (.clock, .fetch_req, .fetch_addr,
    .mode1(bus_mode_select == 3'h5), .ready_n, .fault_n, .halt_n,
    .data(fetch_data));
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic hwait();
    repeat (20) begin
      @(posedge clock);
      if (hreadyout === 1'b1) return;
    end
    fails++;
    results();
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hwait();
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    rd = hrdata;
  endtask
  task automatic idle();
    repeat (3) @(posedge clock);
    repeat (60) begin
      bus(0, 8'h1c, 0);
      if (rd[2:0] === 3'h1) return;
    end
    fails++;
    results();
  endtask
  task automatic reboot(input logic a, input logic [2:0] m);
    rst_n <= 0;
    autostart_n <= a;
    bus_mode_select <= m;
    repeat (5) @(posedge clock);
    rst_n <= 1;
    @(posedge clock);
  endtask
  task automatic irq_chk(input logic [7:0] a, input logic [31:0] d,
                         input logic e);
    bus(1, a, d);
    repeat (2) @(posedge clock);
    `CHK("irq", e, irq)
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_host_mem_model.retries = 1;
    reboot(1'b0, 3'h4);
    repeat (10) @(posedge clock);
    `CHK("boot ptr", 32'h0, fetch_addr)
    `CHK("tip", 1'b1, tip_oe)
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      @(posedge clock);
      if (!rows[i].w) `CHK("rdata", rows[i].d, rd)
      `CHK("locality", rows[i].loc, loc_w)
      `CHK("gpio_oe", rows[i].oe, gpio_oe)
    end
    bus(1, 8'h0c, 32'h15);
    @(posedge clock);
    `CHK("gpio_o", 5'h15, gpio_o)
    idle();
    bus(0, 8'h24, 0);
    `CHK("retries", 32'h1, rd)
    bus(0, 8'h20, 0);
    `CHK("instr", 32'h9800_0000, rd)
    illegal_access <= 1;
    @(posedge clock);
    illegal_access <= 0;
    repeat (3) @(posedge clock);
    bus(0, 8'h14, 0);
    `CHK("status", 32'hd, rd)
    irq_chk(8'h18, 32'h8, 1'b1);
    irq_chk(8'h18, 32'h0, 1'b0);
    irq_chk(8'h18, 32'h4, 1'b1);
    irq_chk(8'h14, 32'hf, 1'b0);
    // Board tester holds the straps high while it walks the tree
    autostart_n <= 1;
    bus_mode_select <= 3'h7;
    tree_test_enable_n <= 0;
    repeat (8) @(posedge clock);
    `CHK("tree oe", 1'b1, tree_oe)
    `CHK("tree high", 1'b1, tree_w)
    `CHK("loc oe", 1'b0, loc_oe)
    for (int i = 0; i < 16; i++) begin
      host_pins_i <= ~(16'h1 << i);
      repeat (5) @(posedge clock);
      `CHK("tree low", 1'b0, tree_w)
    end
    host_pins_i <= 16'hffff;
    tree_test_enable_n <= 1;
    repeat (6) @(posedge clock);
    `CHK("tree off", 1'b0, tree_oe)
    `CHK("loc back", 1'b1, loc_oe)
    reboot(1'b1, 3'h5);
    repeat (20) @(posedge clock);
    `CHK("no start", 1'b0, fetch_req)
    i_host_mem_model.retries = 1;
    bus(1, 8'h04, 32'h100);
    repeat (3) @(posedge clock);
    `CHK("start", 32'h100, fetch_addr)
    `CHK("tip off", 1'b0, tip_oe)
    idle();
    bus(0, 8'h24, 0);
    `CHK("retries", 32'h1, rd)
    bus(0, 8'h20, 0);
    `CHK("instr", 32'h9800_0000, rd)
    i_host_mem_model.fatal = 1;
    bus(1, 8'h14, 32'hf);
    bus(1, 8'h04, 32'h200);
    idle();
    i_host_mem_model.fatal = 0;
    bus(0, 8'h14, 0);
    `CHK("fatal", 32'h2, rd)
    results();
  end
endmodule
